// ===== rtl/ubp_clkdiv.sv
// Clock-output divider for the general-purpose clock pin.
// Assumes run and div are synchronous to clock.
`timescale 1ns/1ps
`include "ubp_regs.svh"
module ubp_clkdiv (
   input  wire logic       clock,
   input  wire logic       resetn,
   input  wire logic       run,
   input  wire logic [7:0] div,
   output logic            clk_r,
   output logic            bypass_r
);
   import ubp_pkg::*;
   logic [7:0] cnt_r;
   wire        wrap = (div == `UBP_DIV_DEF) || (cnt_r >= div - 8'h01);
   // ****************************************************************
   // Divider
   // ****************************************************************
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_r    <= 8'h00;
         clk_r    <= 1'b0;
         bypass_r <= 1'b0;
      end else if (!run) begin
         cnt_r    <= 8'h00;
         clk_r    <= 1'b0;
         bypass_r <= 1'b0;
      end else begin
         bypass_r <= (div == `UBP_DIV_DEF);
         cnt_r    <= wrap ? 8'h00 : cnt_r + 8'h01;
         clk_r    <= wrap ? ~clk_r : clk_r;
      end
   end
   // ****************************************************************
   // Checks
   // ****************************************************************
   a_div_zero: assert property (@(posedge clock) disable iff (!resetn)
      (run && div == 8'h00) |=> bypass_r && $changed(clk_r))
      else $error("divider zero did not run at full rate");
   a_div_hold: assert property (@(posedge clock) disable iff (!resetn)
      (run && div != 8'h00 && cnt_r < div - 8'h01) |=> $stable(clk_r))
      else $error("clock toggled before divider count");
   a_div_flip: assert property (@(posedge clock) disable iff (!resetn)
      (run && div != 8'h00 && cnt_r == div - 8'h01) |=> $changed(clk_r))
      else $error("clock missed toggle at divider count");
endmodule

// ===== rtl/ubp_pin_functions.sv
// Pin alternate functions, configuration store and flow control
// for a serial bridge: clock out, RTS/CTS, RS-485 enable, LEDs.
// Assumes all inputs are synchronous to clock; pads resolve the
// three-signal pins outside this module.
`timescale 1ns/1ps
`include "ubp_regs.svh"
module ubp_pin_functions #(
   parameter int ACT_HALF_CYC = `UBP_ACT_HALF_NS / `UBP_CLK_NS
) (
   input  wire logic             clock,
   input  wire logic             resetn,
   input  wire logic [9:0]       gpio_in,
   input  wire logic [9:0]       gpio_wr_data,
   output logic      [9:0]       gpio_out,
   output logic      [9:0]       gpio_oe,
   output logic      [9:0]       gpio_rd,
   output logic                  clk_bypass,
   input  wire logic             enum_done,
   input  wire logic             suspend,
   input  wire logic             hw_flow_en,
   input  wire logic [8:0]       rx_fill,
   input  wire logic             tx_byte_start,
   output logic                  tx_allow,
   input  wire logic             tx_busy,
   input  wire logic             break_busy,
   input  wire logic             tx_active,
   input  wire logic             rx_active,
   input  wire logic             host_open,
   output logic                  flush_tx,
   output logic                  flush_rx,
   input  wire logic             prog_valid,
   input  wire ubp_pkg::ubp_grp_t prog_group,
   input  wire logic [19:0]      prog_data,
   output logic                  prog_ack,
   output logic                  prog_nak,
   output logic      [7:0]       prog_locked,
   input  wire logic             str_wr,
   input  wire ubp_pkg::ubp_grp_t str_wr_sel,
   input  wire logic [5:0]       str_wr_idx,
   input  wire logic [7:0]       str_wr_char,
   input  wire ubp_pkg::ubp_grp_t str_rd_sel,
   input  wire logic [5:0]       str_rd_idx,
   output logic      [7:0]       str_rd_char,
   output logic      [5:0]       str_rd_len,
   input  wire logic [31:0]      factory_serial,
   output logic      [15:0]      release_num
);
   import ubp_pkg::*;
   // ****************************************************************
   // Decoding functions
   // ****************************************************************
   function automatic logic is_str(input ubp_grp_t g);
      is_str = (g == UBP_G_MFR) || (g == UBP_G_PROD) || (g == UBP_G_SER);
   endfunction
   function automatic logic [7:0] str_base(input ubp_grp_t g);
      str_base = (g == UBP_G_MFR)  ? `UBP_MFR_BASE :
                 (g == UBP_G_PROD) ? `UBP_PROD_BASE : `UBP_SER_BASE;
   endfunction
   function automatic logic [5:0] str_max(input ubp_grp_t g);
      str_max = (g == UBP_G_SER) ? `UBP_SER_MAX : `UBP_LONG_MAX;
   endfunction
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      hex_char = (n < `UBP_NIB_TEN) ? `UBP_ASCII_0 + {4'h0, n}
                                    : `UBP_ASCII_A + {4'h0, n};
   endfunction
   // ****************************************************************
   // Configuration store
   // ****************************************************************
   logic [7:0]  locked_r;
   logic [19:0] mode_r;
   logic [7:0]  div_r;
   logic        de_low_r;
   logic        flush_cfg_r;
   logic [15:0] rel_r;
   logic [5:0]  len_r [3];
   logic [7:0]  str_mem_r [`UBP_STR_TOTAL];
   logic        prog_ack_r;
   logic        prog_nak_r;
   wire         grp_free = !locked_r[prog_group];
   wire         take     = prog_valid && grp_free;
   wire [1:0]   len_slot = 2'(prog_group - UBP_G_MFR);
   wire [5:0]   len_lim  = (prog_data[5:0] > str_max(prog_group)) ?
                           str_max(prog_group) : prog_data[5:0];
   wire         wr_ok    = str_wr && is_str(str_wr_sel) &&
                           !locked_r[str_wr_sel] &&
                           (str_wr_idx < str_max(str_wr_sel));
   wire [7:0]   wr_addr  = str_base(str_wr_sel) + {2'b00, str_wr_idx};
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         locked_r    <= 8'h00;
         mode_r      <= `UBP_MODE_DEF;
         div_r       <= `UBP_DIV_DEF;
         de_low_r    <= `UBP_DE_LOW_DEF;
         flush_cfg_r <= `UBP_FLUSH_DEF;
         rel_r       <= `UBP_REL_DEF;
         len_r       <= '{default: 6'h00};
         prog_ack_r  <= 1'b0;
         prog_nak_r  <= 1'b0;
      end else begin
         prog_ack_r <= take;
         prog_nak_r <= prog_valid && !grp_free;
         if (take) begin
            locked_r[prog_group] <= 1'b1;
            unique case (prog_group)
               UBP_G_GPIO: mode_r      <= prog_data;
               UBP_G_DIV:  div_r       <= prog_data[7:0];
               UBP_G_DE:   de_low_r    <= prog_data[0];
               UBP_G_FLSH: flush_cfg_r <= prog_data[0];
               UBP_G_REL:  rel_r       <= prog_data[15:0];
               UBP_G_MFR,
               UBP_G_PROD,
               UBP_G_SER:  len_r[len_slot] <= len_lim;
            endcase
         end
      end
   end
   always_ff @(posedge clock) begin
      if (wr_ok) begin
         str_mem_r[wr_addr] <= str_wr_char;
      end
   end
   // ****************************************************************
   // String and release readback
   // ****************************************************************
   logic [7:0]  rd_char_r;
   logic [5:0]  rd_len_r;
   wire  [1:0]  rd_slot  = 2'(str_rd_sel - UBP_G_MFR);
   wire  [7:0]  rd_addr  = str_base(str_rd_sel) + {2'b00, str_rd_idx};
   wire         ser_dflt = (str_rd_sel == UBP_G_SER) &&
                           !locked_r[UBP_G_SER];
   wire  [4:0]  nib_pos  = `UBP_SER_TOP - {str_rd_idx[2:0], 2'b00};
   wire  [7:0]  ser_char = (str_rd_idx < `UBP_SER_DIGITS) ?
                           hex_char(factory_serial[nib_pos +: 4]) : 8'h00;
   wire  [5:0]  len_nxt  = !is_str(str_rd_sel) ? 6'h00 :
                           ser_dflt ? `UBP_SER_DIGITS : len_r[rd_slot];
   wire  [7:0]  char_nxt = !is_str(str_rd_sel) ? 8'h00 :
                           ser_dflt ? ser_char :
                           (str_rd_idx < len_r[rd_slot]) ?
                           str_mem_r[rd_addr] : 8'h00;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rd_char_r <= 8'h00;
         rd_len_r  <= 6'h00;
      end else begin
         rd_char_r <= char_nxt;
         rd_len_r  <= len_nxt;
      end
   end
   // ****************************************************************
   // Clock output
   // ****************************************************************
   wire [1:0] m0       = mode_r[2*`UBP_PIN_CLK +: 2];
   wire       clk_sel  = (m0 == UBP_M_ALT);
   wire       clk_run  = clk_sel && enum_done && !suspend;
   logic      clk_div_r;
   logic      clk_byp_r;
   ubp_clkdiv u_clkdiv (
      .clock    (clock),
      .resetn   (resetn),
      .run      (clk_run),
      .div      (div_r),
      .clk_r    (clk_div_r),
      .bypass_r (clk_byp_r)
   );
   // ****************************************************************
   // Flow control
   // ****************************************************************
   wire         rts_on  = (mode_r[2*`UBP_PIN_RTS +: 2] == UBP_M_ALT) &&
                          hw_flow_en;
   wire         cts_on  = (mode_r[2*`UBP_PIN_CTS +: 2] == UBP_M_ALT) &&
                          hw_flow_en;
   wire         cts_hi  = cts_on && gpio_in[`UBP_PIN_CTS];
   wire         rts_val = (rx_fill >= `UBP_RTS_MARK);
   ubp_cts_st_t cts_st_r;
   ubp_cts_st_t cts_nxt;
   logic        allow_r;
   always_comb begin
      cts_nxt = cts_st_r;
      if (!cts_hi) begin
         cts_nxt = UBP_CTS_GO;
      end else begin
         unique case (cts_st_r)
            UBP_CTS_GO:   cts_nxt = tx_byte_start ? UBP_CTS_ONE
                                                  : UBP_CTS_ZERO;
            UBP_CTS_ZERO: cts_nxt = tx_byte_start ? UBP_CTS_ONE
                                                  : UBP_CTS_ZERO;
            UBP_CTS_ONE:  cts_nxt = tx_byte_start ? UBP_CTS_STOP
                                                  : UBP_CTS_ONE;
            UBP_CTS_STOP: cts_nxt = UBP_CTS_STOP;
         endcase
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cts_st_r <= UBP_CTS_GO;
         allow_r  <= 1'b1;
      end else begin
         cts_st_r <= cts_nxt;
         allow_r  <= (cts_nxt != UBP_CTS_STOP);
      end
   end
   // ****************************************************************
   // Driver enable and activity pins
   // ****************************************************************
   wire        de_val = (tx_busy || break_busy) ^ de_low_r;
   wire [1:0]  busy   = {rx_active, tx_active};
   logic [1:0] act_r;
   logic [22:0] act_cnt_r [2];
   for (genvar d = 0; d < 2; d++) begin : g_act
      wire done = (act_cnt_r[d] >= 23'(ACT_HALF_CYC - 1));
      always_ff @(posedge clock or negedge resetn) begin
         if (!resetn) begin
            act_r[d]     <= 1'b1;
            act_cnt_r[d] <= 23'h000000;
         end else if (!busy[d]) begin
            act_r[d]     <= 1'b1;
            act_cnt_r[d] <= 23'h000000;
         end else begin
            act_r[d]     <= done ? ~act_r[d] : act_r[d];
            act_cnt_r[d] <= done ? 23'h000000 : act_cnt_r[d] + 23'h1;
         end
      end
   end
   // ****************************************************************
   // Pin multiplexing
   // ****************************************************************
   wire [9:0] alt_val = {4'h0, act_r[1], act_r[0], de_val, 1'b0,
                         rts_val, clk_div_r};
   wire [9:0] alt_drv = {4'h0, 3'h7, 1'b0, rts_on, clk_run};
   logic [9:0] out_nxt;
   logic [9:0] oe_nxt;
   for (genvar i = 0; i < `UBP_NPINS; i++) begin : g_pin
      wire [1:0] m = mode_r[2*i +: 2];
      assign oe_nxt[i]  = (m == UBP_M_PP) ||
                          ((m == UBP_M_OD) && !gpio_wr_data[i]) ||
                          ((m == UBP_M_ALT) && alt_drv[i]);
      assign out_nxt[i] = (m == UBP_M_PP)  ? gpio_wr_data[i] :
                          (m == UBP_M_ALT) ? alt_val[i] : 1'b0;
   end
   logic [9:0] out_r;
   logic [9:0] oe_r;
   logic [9:0] rd_r;
   logic       flush_tx_r;
   logic       flush_rx_r;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         out_r      <= 10'h000;
         oe_r       <= 10'h000;
         rd_r       <= 10'h000;
         flush_tx_r <= 1'b0;
         flush_rx_r <= 1'b0;
      end else begin
         out_r      <= out_nxt;
         oe_r       <= oe_nxt;
         rd_r       <= gpio_in;
         flush_tx_r <= host_open && flush_cfg_r;
         flush_rx_r <= host_open && flush_cfg_r;
      end
   end
   assign gpio_out    = out_r;
   assign gpio_oe     = oe_r;
   assign gpio_rd     = rd_r;
   assign clk_bypass  = clk_byp_r;
   assign tx_allow    = allow_r;
   assign flush_tx    = flush_tx_r;
   assign flush_rx    = flush_rx_r;
   assign prog_ack    = prog_ack_r;
   assign prog_nak    = prog_nak_r;
   assign prog_locked = locked_r;
   assign str_rd_char = rd_char_r;
   assign str_rd_len  = rd_len_r;
   assign release_num = rel_r;
   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_tx_idle;
      !tx_active [*2];
   endsequence
   sequence s_cts_second;
      cts_hi && (cts_st_r == UBP_CTS_ONE) && tx_byte_start;
   endsequence
   a_clk_start: assert property (@(posedge clock) disable iff (!resetn)
      (clk_sel && $rose(oe_r[0])) |-> $past(enum_done) && !$past(suspend))
      else $error("clock out appeared before enumeration");
   a_clk_stop: assert property (@(posedge clock) disable iff (!resetn)
      (clk_sel && suspend) |=> !oe_r[0])
      else $error("clock out still driven in suspend");
   a_rts_high: assert property (@(posedge clock) disable iff (!resetn)
      (rts_on && rx_fill >= `UBP_RTS_MARK) |=> oe_r[1] && out_r[1])
      else $error("rts not high at fill mark");
   a_rts_low: assert property (@(posedge clock) disable iff (!resetn)
      (rts_on && rx_fill < `UBP_RTS_MARK) |=> oe_r[1] && !out_r[1])
      else $error("rts not low below fill mark");
   a_cts_pause: assert property (@(posedge clock) disable iff (!resetn)
      s_cts_second |=> !tx_allow ##0 (cts_hi [*1]) or !cts_hi)
      else $error("third byte allowed after cts high");
   a_cts_free: assert property (@(posedge clock) disable iff (!resetn)
      (!gpio_in[2] || !cts_on) |=> tx_allow)
      else $error("transmit held while cts low");
   a_de_level: assert property (@(posedge clock) disable iff (!resetn)
      ((tx_busy || break_busy) && mode_r[2*`UBP_PIN_DE +: 2] == UBP_M_ALT)
      |=> oe_r[3] && (out_r[3] != $past(de_low_r)))
      else $error("driver enable not asserted during transmit");
   a_act_idle: assert property (@(posedge clock) disable iff (!resetn)
      (s_tx_idle ##0 mode_r[9:8] == 2'b11) |=> out_r[4])
      else $error("activity pin low while idle");
   a_prog_lock: assert property (@(posedge clock) disable iff (!resetn)
      (prog_valid && locked_r[prog_group]) |=> prog_nak && !prog_ack)
      else $error("write to locked group accepted");
   a_prog_take: assert property (@(posedge clock) disable iff (!resetn)
      (prog_valid && !locked_r[prog_group])
      |=> prog_ack && locked_r[$past(prog_group)])
      else $error("accepted write did not lock group");
   a_flush_open: assert property (@(posedge clock) disable iff (!resetn)
      (host_open && flush_cfg_r) |=> flush_tx && flush_rx)
      else $error("fifos not flushed on open");
   a_rel_dflt: assert property (@(posedge clock) disable iff (!resetn)
      !locked_r[4] |-> release_num == 16'h0100)
      else $error("default release number wrong");
endmodule

// ===== rtl/ubp_pkg.sv
// Types for the bridge pin-function block.
// Assumes ubp_regs.svh supplies the numeric constants.
package ubp_pkg;
   typedef enum logic [1:0] {
      UBP_M_IN  = 2'b00,
      UBP_M_OD  = 2'b01,
      UBP_M_PP  = 2'b10,
      UBP_M_ALT = 2'b11
   } ubp_mode_t;
   typedef enum logic [2:0] {
      UBP_G_GPIO = 3'b000,
      UBP_G_DIV  = 3'b001,
      UBP_G_DE   = 3'b010,
      UBP_G_FLSH = 3'b011,
      UBP_G_REL  = 3'b100,
      UBP_G_MFR  = 3'b101,
      UBP_G_PROD = 3'b110,
      UBP_G_SER  = 3'b111
   } ubp_grp_t;
   typedef enum logic [1:0] {
      UBP_CTS_GO   = 2'b00,
      UBP_CTS_ZERO = 2'b01,
      UBP_CTS_ONE  = 2'b10,
      UBP_CTS_STOP = 2'b11
   } ubp_cts_st_t;
endpackage

// ===== rtl/ubp_regs.svh
// Constants for the bridge pin-function block: pin numbers, defaults,
// flow marks, string store layout and timing.
// Assumes a 100 MHz reference clock on the block's clock port.
`ifndef UBP_REGS_SVH
`define UBP_REGS_SVH
// ****************************************************************
// Pins and widths
// ****************************************************************
`define UBP_NPINS      10
`define UBP_PIN_CLK    0
`define UBP_PIN_RTS    1
`define UBP_PIN_CTS    2
`define UBP_PIN_DE     3
`define UBP_PIN_TXACT  4
`define UBP_PIN_RXACT  5
// ****************************************************************
// Built-in defaults
// ****************************************************************
`define UBP_MODE_DEF   20'hA0FFC
`define UBP_DIV_DEF    8'h00
`define UBP_DE_LOW_DEF 1'b0
`define UBP_FLUSH_DEF  1'b1
`define UBP_REL_DEF    16'h0100
// ****************************************************************
// Flow control
// ****************************************************************
`define UBP_RTS_MARK   9'h1C2
// ****************************************************************
// String store
// ****************************************************************
`define UBP_MFR_BASE   8'h00
`define UBP_PROD_BASE  8'h3E
`define UBP_SER_BASE   8'h7C
`define UBP_STR_TOTAL  154
`define UBP_LONG_MAX   6'h3E
`define UBP_SER_MAX    6'h1E
`define UBP_SER_DIGITS 6'h08
`define UBP_SER_TOP    5'h1C
`define UBP_ASCII_0    8'h30
`define UBP_ASCII_A    8'h37
`define UBP_NIB_TEN    4'hA
// ****************************************************************
// Timing
// ****************************************************************
`define UBP_CLK_NS     10
`define UBP_ACT_HALF_NS 50000000
`endif

// ===== sim/tb_uart_bridge_pin_functions.sv
// Self-checking bench for the pin-function block and a far-end peer.
// Assumes the design files and the peer model are compiled first.
`timescale 1ns/1ps
module tb_uart_bridge_pin_functions;
   import ubp_pkg::*;
   logic clock = 1'b0, resetn = 1'b0, clk_bypass, enum_done, suspend;
   logic [9:0] gpio_in, gpio_wr_data, gpio_out, gpio_oe, gpio_rd;
   logic hw_flow_en, tx_byte_start, tx_allow, tx_busy, break_busy;
   logic tx_active, rx_active, host_open, flush_tx, flush_rx;
   logic prog_valid, prog_ack, prog_nak, str_wr;
   logic [8:0] rx_fill;
   logic [19:0] prog_data;
   logic [7:0] prog_locked, str_wr_char, str_rd_char, peer_fill;
   logic [5:0] str_wr_idx, str_rd_idx, str_rd_len;
   logic [31:0] factory_serial;
   logic [15:0] release_num;
   logic cts_n;
   ubp_grp_t prog_group, str_wr_sel, str_rd_sel;
   int fails = 0;
   int n_compared = 0;
   assign gpio_in = {7'h00, cts_n, 2'b00};
   always #5 clock = ~clock;
   ubp_pin_functions #(.ACT_HALF_CYC(4)) dut (.*);
   ubp_uart_peer peer (.clock(clock), .fill(peer_fill), .cts_n(cts_n));
   // ******************************************************
   // Shared tasks
   // ******************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic prog(input ubp_grp_t g, input logic [19:0] d,
                       input logic ok);
      prog_valid = 1'b1;
      prog_group = g;
      prog_data = d;
      tick(1);
      prog_valid = 1'b0;
      chk({prog_ack, prog_nak}, {ok, !ok});
   endtask
   task automatic count_tog(input int b, input int n, output int c);
      logic prev;
      c = 0;
      prev = gpio_out[b];
      repeat (n) begin
         tick(1);
         if (gpio_out[b] !== prev) c++;
         prev = gpio_out[b];
      end
   endtask
   task automatic conclude;
      if (fails == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ******************************************************
   // Scenarios
   // ******************************************************
   task automatic t_defaults;
      chk({gpio_oe[9:8], gpio_out[9:8]}, 4'hF);
      chk({gpio_oe[0], gpio_out[5:4]}, 3'h3);
      chk({release_num, prog_locked}, 24'h010000);
      chk(gpio_out[3], 1'b0);
   endtask
   task automatic t_rts;
      rx_fill = 9'h1C1;
      tick(1);
      chk(gpio_out[1], 1'b0);
      rx_fill = 9'h1C2;
      tick(1);
      chk(gpio_out[1], 1'b1);
      hw_flow_en = 1'b0;
      tick(1);
      chk({gpio_oe[1], tx_allow}, 2'b01);
      hw_flow_en = 1'b1;
      rx_fill = 9'h000;
      tick(1);
      chk({gpio_oe[1], gpio_out[1]}, 2'b10);
   endtask
   task automatic t_cts;
      peer_fill = 8'h20;
      tx_byte_start = 1'b1;
      tick(1);
      chk(tx_allow, 1'b1);
      chk(gpio_rd, 10'h004);
      tick(1);
      tx_byte_start = 1'b0;
      tick(1);
      chk(tx_allow, 1'b0);
      peer_fill = 8'h00;
      tick(1);
      chk(tx_allow, 1'b1);
   endtask
   task automatic t_de;
      tx_busy = 1'b1;
      tick(1);
      chk(gpio_out[3], 1'b1);
      tx_busy = 1'b0;
      break_busy = 1'b1;
      tick(1);
      chk(gpio_out[3], 1'b1);
      break_busy = 1'b0;
      prog(UBP_G_DE, 20'h00001, 1'b1);
      tick(1);
      chk(gpio_out[3], 1'b1);
      tx_busy = 1'b1;
      tick(1);
      chk(gpio_out[3], 1'b0);
      tx_busy = 1'b0;
      prog(UBP_G_DE, 20'h00000, 1'b0);
      chk(prog_locked[2], 1'b1);
   endtask
   task automatic t_flush;
      host_open = 1'b1;
      tick(1);
      host_open = 1'b0;
      chk({flush_tx, flush_rx}, 2'b11);
      tick(1);
      chk({flush_tx, flush_rx}, 2'b00);
      prog(UBP_G_FLSH, 20'h00000, 1'b1);
      host_open = 1'b1;
      tick(1);
      host_open = 1'b0;
      chk({flush_tx, flush_rx}, 2'b00);
      prog(UBP_G_REL, 20'h01234, 1'b1);
      chk(release_num, 16'h1234);
   endtask
   task automatic t_clk;
      int c;
      prog(UBP_G_GPIO, 20'hA1FFF, 1'b1);
      enum_done = 1'b1;
      tick(2);
      chk(gpio_oe[0], 1'b0);
      chk({gpio_oe[6], gpio_out[6]}, 2'b10);
      suspend = 1'b0;
      tick(1);
      chk(gpio_oe[0], 1'b1);
      tick(2);
      chk(clk_bypass, 1'b1);
      prog(UBP_G_DIV, 20'h00003, 1'b1);
      tick(4);
      count_tog(0, 24, c);
      chk(c, 8);
      chk(clk_bypass, 1'b0);
      suspend = 1'b1;
      tick(1);
      chk(gpio_oe[0], 1'b0);
   endtask
   task automatic t_act;
      int c;
      tx_active = 1'b1;
      rx_active = 1'b1;
      tick(2);
      count_tog(4, 16, c);
      chk(c, 4);
      count_tog(5, 16, c);
      chk(c, 4);
      tx_active = 1'b0;
      rx_active = 1'b0;
      tick(2);
      chk(gpio_out[5:4], 2'b11);
   endtask
   task automatic t_serial;
      logic [3:0] nib;
      str_rd_sel = UBP_G_SER;
      for (int i = 0; i < 8; i++) begin
         str_rd_idx = 6'(i);
         nib = factory_serial[31 - 4 * i -: 4];
         tick(1);
         chk(str_rd_char, (nib < 4'hA) ? 8'h30 + nib : 8'h37 + nib);
      end
      chk(str_rd_len, 6'h08);
      str_rd_sel = UBP_G_MFR;
      tick(1);
      chk(str_rd_len, 6'h00);
   endtask
   task automatic t_str;
      str_wr_sel = UBP_G_PROD;
      str_wr_char = 8'h41;
      str_wr = 1'b1;
      tick(1);
      str_wr_idx = 6'h3D;
      str_wr_char = 8'h5A;
      tick(1);
      str_wr = 1'b0;
      prog(UBP_G_PROD, 20'h0003F, 1'b1);
      str_rd_sel = UBP_G_PROD;
      str_rd_idx = 6'h3D;
      tick(1);
      chk({str_rd_len, str_rd_char}, 14'h3E5A);
      str_wr = 1'b1;
      str_wr_idx = 6'h00;
      str_wr_char = 8'h42;
      str_rd_idx = 6'h00;
      tick(1);
      str_wr = 1'b0;
      tick(1);
      chk(str_rd_char, 8'h41);
      prog(UBP_G_SER, 20'h0003F, 1'b1);
      str_rd_sel = UBP_G_SER;
      tick(1);
      chk(str_rd_len, 6'h1E);
   endtask
   initial begin
      {enum_done, tx_byte_start, tx_busy, break_busy, str_wr} = 5'h00;
      {tx_active, rx_active, host_open, prog_valid} = 4'h0;
      {suspend, hw_flow_en} = 2'b11;
      gpio_wr_data = 10'h300;
      rx_fill = 9'h000;
      peer_fill = 8'h00;
      prog_group = UBP_G_GPIO;
      prog_data = 20'h00000;
      str_wr_sel = UBP_G_GPIO;
      str_rd_sel = UBP_G_GPIO;
      {str_wr_idx, str_rd_idx, str_wr_char} = 20'h00000;
      factory_serial = 32'h9A0F5C3B;
      tick(12);
      resetn = 1'b1;
      tick(1);
      t_defaults();
      t_rts();
      t_cts();
      t_de();
      t_flush();
      t_clk();
      t_act();
      t_serial();
      t_str();
      conclude();
   end
   initial begin
      #200000;
      fails++;
      conclude();
   end
endmodule

// ===== sim/ubp_uart_peer.sv
// Far-end UART device model: drives the active-low clear-to-send line.
// Assumes the bench changes fill off the rising clock edge.
`timescale 1ns/1ps
module ubp_uart_peer #(
   parameter int NEAR_FULL = 16,
   parameter int LAG       = 0
) (
   clock,
   fill,
   cts_n
);
   input  wire logic       clock;
   input  wire logic [7:0] fill;
   output logic            cts_n;
   logic [3:0] hist_r = 4'h0;
   logic       near_full;
   // High when nearly full, low while room remains; LAG answers slowly
   assign near_full = (fill >= NEAR_FULL);
   always_ff @(posedge clock) begin
      hist_r <= {hist_r[2:0], near_full};
   end
   assign cts_n = (LAG == 0) ? near_full : hist_r[(LAG > 0) ? LAG - 1 : 0];
endmodule
